// >>> obp_consts.svh
// Constants for the bitmap and pointer overlay planes
`ifndef OBP_CONSTS_SVH
`define OBP_CONSTS_SVH

`define OBP_BMP_BYTES     4096
`define OBP_BMP_ABITS     12
`define OBP_BMP_BITABITS  15
`define OBP_ICON_BYTES    512
`define OBP_ICON_SIDE     32
`define OBP_ICON_LAST     5'h1f
`define OBP_BIT_STEP      15'h0008
`define OBP_BCA_MIRROR    0
`define OBP_BCA_FLIP      1
`define OBP_BCA_ROTATE    2
`define OBP_BCA_ZOOM      3
`define OBP_BCA_BEHIND    6
`define OBP_BCA_ENABLE    7
`define OBP_BCB_DEPTH_HI  6
`define OBP_BCB_DEPTH_LO  5
`define OBP_CB_FORE_CLR   4
`define OBP_CB_BACK_CLR   3
`define OBP_ICA_SEL       6
`define OBP_ICA_AUTO      7
`define OBP_ICB_IRQ_EN    5
`define OBP_ICB_ENABLE    7
`define OBP_DEPTH_1BPP    2'h0
`define OBP_DEPTH_2BPP    2'h1
`define OBP_BG_INDEX      4'h0
`define OBP_MASK_ALL      8'hff

`endif

// >>> obp_host_model.sv
// Host model that issues cursor, pixel and acknowledge writes
`default_nettype none
module obp_host_model (
  input  wire logic        clk_in,
  output logic             bcl_out,
  output logic [10:0]      bcx_out,
  output logic [10:0]      bcy_out,
  output logic             bwe_out,
  output logic [7:0]       bd_out,
  output logic [7:0]       bm_out,
  output logic             icl_out,
  output logic [4:0]       icx_out,
  output logic [4:0]       icy_out,
  output logic             iwe_out,
  output logic [7:0]       id_out,
  output logic [1:0]       iw_out,
  output logic             ack_out
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    {bcl_out, bcx_out, bcy_out, bwe_out, bd_out, bm_out} = '0;
    {icl_out, icx_out, icy_out, iwe_out, id_out, iw_out, ack_out} = '0;
  end
  task automatic step();
    @(posedge clk_in);
    #1;
  endtask
  // Released data lines show a changed value, not the last one
  task automatic idle();
    {bcl_out, bwe_out, icl_out, iwe_out, ack_out} = '0;
    bd_out = ~bd_out;
    id_out = ~id_out;
    step();
  endtask
  task automatic bmp_cur(input logic [10:0] x, input logic [10:0] y);
    {bcl_out, bwe_out, bcx_out, bcy_out} = {2'b10, x, y};
    step();
  endtask
  // Mask comes from caller, which keeps trailing pixels intact
  task automatic bmp_wr(input logic [7:0] d, input logic [7:0] m);
    {bcl_out, bwe_out, bd_out, bm_out} = {2'b01, d, m};
    step();
  endtask
  task automatic icon_cur(input logic [4:0] x, input logic [4:0] y);
    {icl_out, iwe_out, icx_out, icy_out} = {2'b10, x, y};
    step();
  endtask
  task automatic icon_wr(input logic [7:0] d, input logic [1:0] w);
    {icl_out, iwe_out, id_out, iw_out} = {2'b01, d, w};
    step();
  endtask
  task automatic ack();
    ack_out = 1'b1;
    step();
  endtask
endmodule
`default_nettype wire

// >>> obp_pkg.sv
// Types for the bitmap and pointer overlay planes
`default_nettype none
package obp_pkg;
  typedef enum logic [1:0] {OBP_PL_NONE, OBP_PL_TEXT, OBP_PL_BMP, OBP_PL_ICON} obp_plane_t;

  typedef struct packed {
    logic [10:0] pos_x;
    logic [10:0] pos_y;
    logic [7:0]  ctrl_a;
    logic [7:0]  ctrl_b;
    logic [7:0]  fore_blend;
    logic [7:0]  back_blend;
  } obp_plane_cfg_t;

  typedef struct packed {
    obp_plane_t  plane;
    logic [3:0]  colour;
    logic [7:0]  blend;
  } obp_pix_t;
endpackage
`default_nettype wire

// >>> obp_planes.sv
// Bitmap and pointer overlay planes with masked writes and animation
//
// Behaviour
// - Bitmap placed anywhere, zoomed, mirrored, rotated
// - Bitmap over text unless behind flag set
// - Two bitmap blend factors, two transparency flags
// - Sixteen palette colours, value zero is background
// - Bitmap store is four kbyte
// - Depth code gives one, two, four bits
// - Byte writes MSB first from cursor, unaligned
// - Only masked bits written, live writes allowed
// - Bit address advances eight per data write
// - Icon fixed 32x32, two bits, zero background
// - Icon always above text and bitmap
// - Icon blend factors and transparency flags
// - Buffer select bit, or auto swap per interrupt
// - Icon writes go to inactive buffer
// - Animation interrupt every programmed frames when enabled
// - Icon data MSB first, two bits, unmasked
// - Width field sets pixels per write, advance
// - Data strobe repeats, full buffer in 256
// - All planes off bypasses and stops clock
// - Cursor addresses wrap beyond memory space
`include "obp_consts.svh"
`default_nettype none
module obp_planes #(
  parameter int CW = 11
) (
  input  wire logic                   clk_in,
  input  wire logic                   rst_in,
  input  wire obp_pkg::obp_plane_cfg_t bmp_cfg_in,
  input  wire logic [CW-1:0]          bitmap_width_in,
  input  wire logic [CW-1:0]          bitmap_height_in,
  input  wire logic                   bitmap_cursor_load_in,
  input  wire logic [CW-1:0]          bitmap_cursor_x_in,
  input  wire logic [CW-1:0]          bitmap_cursor_y_in,
  input  wire logic                   bitmap_data_we_in,
  input  wire logic [7:0]             bitmap_pixel_data_in,
  input  wire logic [7:0]             bitmap_write_mask_in,
  input  wire obp_pkg::obp_plane_cfg_t icon_cfg_in,
  input  wire logic [1:0]             icon_write_width_in,
  input  wire logic [7:0]             anim_frame_period_in,
  input  wire logic                   icon_cursor_load_in,
  input  wire logic [4:0]             icon_cursor_x_in,
  input  wire logic [4:0]             icon_cursor_y_in,
  input  wire logic                   icon_data_we_in,
  input  wire logic [7:0]             icon_pixel_data_in,
  input  wire logic                   anim_irq_ack_in,
  input  wire logic                   text_on_in,
  input  wire obp_pkg::obp_pix_t      text_pix_in,
  input  wire logic                   frame_start_in,
  input  wire logic [CW-1:0]          pix_x_in,
  input  wire logic [CW-1:0]          pix_y_in,
  output obp_pkg::obp_pix_t           pix_out,
  output logic                        osd_clk_en_out,
  output logic                        anim_irq_out,
  output logic                        icon_shown_buf_out
);
  logic [7:0]  bmp_mem [`OBP_BMP_BYTES];
  logic [7:0]  icon_mem [`OBP_ICON_BYTES];
  logic [14:0] bmp_bit_addr;
  logic [9:0]  icon_ptr;
  logic [7:0]  frame_cnt;
  logic        auto_buf;
  logic        bmp_on;
  logic        icon_on;
  logic        shown_buf;
  logic        anim_event;
  logic [1:0]  bmp_shift;

  assign bmp_on  = bmp_cfg_in.ctrl_a[`OBP_BCA_ENABLE];
  assign icon_on = icon_cfg_in.ctrl_b[`OBP_ICB_ENABLE];

  // Depth code 00, 01, 1x as shift of one bit per pixel
  always_comb begin
    unique case (bmp_cfg_in.ctrl_b[`OBP_BCB_DEPTH_HI:`OBP_BCB_DEPTH_LO])
      `OBP_DEPTH_1BPP: bmp_shift = 2'h0;
      `OBP_DEPTH_2BPP: bmp_shift = 2'h1;
      default:         bmp_shift = 2'h2;
    endcase
  end

  // Bitmap write cursor, bit exact and wrapping
  logic [21:0] cur_pix;
  logic [23:0] cur_bits;
  assign cur_pix  = 22'(bitmap_cursor_y_in) * 22'(bitmap_width_in) + 22'(bitmap_cursor_x_in);
  assign cur_bits = {2'h0, cur_pix} << bmp_shift;

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      bmp_bit_addr <= '0;
    end else if (bitmap_cursor_load_in) begin
      bmp_bit_addr <= cur_bits[`OBP_BMP_BITABITS-1:0];
    end else if (bitmap_data_we_in) begin
      bmp_bit_addr <= bmp_bit_addr + `OBP_BIT_STEP;
    end
  end

  // Masked read-modify-write over two neighbouring bytes
  logic [11:0] wb0;
  logic [11:0] wb1;
  logic [15:0] bwin;
  logic [15:0] bdat;
  logic [15:0] bmsk;
  logic [15:0] bnew;
  always_comb begin
    wb0  = bmp_bit_addr[14:3];
    wb1  = wb0 + 12'h001;
    bwin = {bmp_mem[wb0], bmp_mem[wb1]};
    bdat = {bitmap_pixel_data_in, 8'h00} >> bmp_bit_addr[2:0];
    bmsk = {bitmap_write_mask_in, 8'h00} >> bmp_bit_addr[2:0];
    bnew = (bwin & ~bmsk) | (bdat & bmsk);
  end

  always_ff @(posedge clk_in) begin
    if (bitmap_data_we_in) begin
      bmp_mem[wb0] <= bnew[15:8];
      bmp_mem[wb1] <= bnew[7:0];
    end
  end

  // Icon animation frame counter and interrupt
  assign anim_event = frame_start_in && icon_cfg_in.ctrl_b[`OBP_ICB_IRQ_EN]
    && ({1'b0, frame_cnt} + 9'h001 >= {1'b0, anim_frame_period_in});

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      frame_cnt <= '0;
    end else if (frame_start_in) begin
      if ({1'b0, frame_cnt} + 9'h001 >= {1'b0, anim_frame_period_in}) begin
        frame_cnt <= '0;
      end else begin
        frame_cnt <= frame_cnt + 8'h01;
      end
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      anim_irq_out <= 1'b0;
    end else if (anim_event) begin
      anim_irq_out <= 1'b1;
    end else if (anim_irq_ack_in) begin
      anim_irq_out <= 1'b0;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      auto_buf <= 1'b0;
    end else if (anim_event) begin
      auto_buf <= ~auto_buf;
    end
  end

  assign shown_buf = icon_cfg_in.ctrl_a[`OBP_ICA_AUTO] ? auto_buf
    : icon_cfg_in.ctrl_a[`OBP_ICA_SEL];
  assign icon_shown_buf_out = shown_buf;

  // Icon write cursor, advance by pixels used
  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      icon_ptr <= '0;
    end else if (icon_cursor_load_in) begin
      icon_ptr <= {icon_cursor_y_in, icon_cursor_x_in};
    end else if (icon_data_we_in) begin
      icon_ptr <= icon_ptr + {8'h00, icon_write_width_in} + 10'h001;
    end
  end

  logic [8:0]  ib0;
  logic [8:0]  ib1;
  logic [2:0]  ioff;
  logic [7:0]  iwm8;
  logic [15:0] iwin;
  logic [15:0] idat;
  logic [15:0] imsk;
  logic [15:0] inew;
  always_comb begin
    ib0  = {~shown_buf, icon_ptr[9:2]};
    ib1  = {~shown_buf, icon_ptr[9:2] + 8'h01};
    ioff = {icon_ptr[1:0], 1'b0};
    iwm8 = 8'(`OBP_MASK_ALL << {~icon_write_width_in, 1'b0});
    iwin = {icon_mem[ib0], icon_mem[ib1]};
    idat = {icon_pixel_data_in, 8'h00} >> ioff;
    imsk = {iwm8, 8'h00} >> ioff;
    inew = (iwin & ~imsk) | (idat & imsk);
  end

  always_ff @(posedge clk_in) begin
    if (icon_data_we_in) begin
      icon_mem[ib0] <= inew[15:8];
      icon_mem[ib1] <= inew[7:0];
    end
  end

  // Bitmap raster lookup with zoom, rotation and mirroring
  logic [CW-1:0] bdx;
  logic [CW-1:0] bdy;
  logic [CW-1:0] blx;
  logic [CW-1:0] bly;
  logic          bmp_in;
  logic [21:0]   brd_pix;
  logic [23:0]   brd_bits;
  logic [7:0]    brd_byte;
  logic [3:0]    bmp_val;
  logic          bmp_vis;
  always_comb begin
    bdx = (pix_x_in - bmp_cfg_in.pos_x) >> bmp_cfg_in.ctrl_a[`OBP_BCA_ZOOM];
    bdy = (pix_y_in - bmp_cfg_in.pos_y) >> bmp_cfg_in.ctrl_a[`OBP_BCA_ZOOM];
    blx = bmp_cfg_in.ctrl_a[`OBP_BCA_ROTATE] ? bdy : bdx;
    bly = bmp_cfg_in.ctrl_a[`OBP_BCA_ROTATE] ? bdx : bdy;
    bmp_in = (pix_x_in >= bmp_cfg_in.pos_x) && (pix_y_in >= bmp_cfg_in.pos_y)
      && (blx < bitmap_width_in) && (bly < bitmap_height_in);
    if (bmp_cfg_in.ctrl_a[`OBP_BCA_MIRROR]) begin
      blx = bitmap_width_in - blx - CW'(1);
    end
    if (bmp_cfg_in.ctrl_a[`OBP_BCA_FLIP]) begin
      bly = bitmap_height_in - bly - CW'(1);
    end
    brd_pix  = 22'(bly) * 22'(bitmap_width_in) + 22'(blx);
    brd_bits = {2'h0, brd_pix} << bmp_shift;
    brd_byte = bmp_mem[brd_bits[14:3]] << brd_bits[2:0];
    unique case (bmp_shift)
      2'h0:    bmp_val = {3'h0, brd_byte[7]};
      2'h1:    bmp_val = {2'h0, brd_byte[7:6]};
      default: bmp_val = brd_byte[7:4];
    endcase
    bmp_vis = bmp_on && bmp_in
      && !((bmp_val == `OBP_BG_INDEX) ? bmp_cfg_in.ctrl_b[`OBP_CB_BACK_CLR]
                                      : bmp_cfg_in.ctrl_b[`OBP_CB_FORE_CLR]);
  end

  // Icon raster lookup from the shown buffer
  logic [CW-1:0] idx;
  logic [CW-1:0] idy;
  logic [4:0]    ilx;
  logic [4:0]    ily;
  logic          icon_in;
  logic [7:0]    ird_byte;
  logic [1:0]    icon_val;
  logic          icon_vis;
  always_comb begin
    idx = (pix_x_in - icon_cfg_in.pos_x) >> icon_cfg_in.ctrl_a[`OBP_BCA_ZOOM];
    idy = (pix_y_in - icon_cfg_in.pos_y) >> icon_cfg_in.ctrl_a[`OBP_BCA_ZOOM];
    icon_in = (pix_x_in >= icon_cfg_in.pos_x) && (pix_y_in >= icon_cfg_in.pos_y)
      && (idx < CW'(`OBP_ICON_SIDE)) && (idy < CW'(`OBP_ICON_SIDE));
    ilx = icon_cfg_in.ctrl_a[`OBP_BCA_ROTATE] ? idy[4:0] : idx[4:0];
    ily = icon_cfg_in.ctrl_a[`OBP_BCA_ROTATE] ? idx[4:0] : idy[4:0];
    if (icon_cfg_in.ctrl_a[`OBP_BCA_MIRROR]) begin
      ilx = `OBP_ICON_LAST - ilx;
    end
    if (icon_cfg_in.ctrl_a[`OBP_BCA_FLIP]) begin
      ily = `OBP_ICON_LAST - ily;
    end
    ird_byte = icon_mem[{shown_buf, ily, ilx[4:2]}] << {ilx[1:0], 1'b0};
    icon_val = ird_byte[7:6];
    icon_vis = icon_on && icon_in
      && !((icon_val == 2'h0) ? icon_cfg_in.ctrl_b[`OBP_CB_BACK_CLR]
                              : icon_cfg_in.ctrl_b[`OBP_CB_FORE_CLR]);
  end

  // Layer composition, registered
  obp_pkg::obp_pix_t next_pix;
  logic              text_vis;
  assign text_vis = text_on_in && (text_pix_in.plane != obp_pkg::OBP_PL_NONE);
  assign osd_clk_en_out = text_on_in || bmp_on || icon_on;

  always_comb begin
    next_pix = '{plane: obp_pkg::OBP_PL_NONE, colour: 4'h0, blend: 8'h00};
    if (!osd_clk_en_out) begin
      next_pix = '{plane: obp_pkg::OBP_PL_NONE, colour: 4'h0, blend: 8'h00};
    end else if (icon_vis) begin
      next_pix.plane  = obp_pkg::OBP_PL_ICON;
      next_pix.colour = {2'h0, icon_val};
      next_pix.blend  = (icon_val == 2'h0) ? icon_cfg_in.back_blend : icon_cfg_in.fore_blend;
    end else if (bmp_vis && !(text_vis && bmp_cfg_in.ctrl_a[`OBP_BCA_BEHIND])) begin
      next_pix.plane  = obp_pkg::OBP_PL_BMP;
      next_pix.colour = bmp_val;
      next_pix.blend  = (bmp_val == `OBP_BG_INDEX) ? bmp_cfg_in.back_blend
                                                   : bmp_cfg_in.fore_blend;
    end else if (text_vis) begin
      next_pix = text_pix_in;
    end
  end

  always_ff @(posedge clk_in or posedge rst_in) begin
    if (rst_in) begin
      pix_out <= '{plane: obp_pkg::OBP_PL_NONE, colour: 4'h0, blend: 8'h00};
    end else begin
      pix_out <= next_pix;
    end
  end

  a_irq_raise_en: assert property (@(posedge clk_in) disable iff (rst_in)
    $rose(anim_irq_out) |-> $past(icon_cfg_in.ctrl_b[`OBP_ICB_IRQ_EN]) && $past(frame_start_in))
    else $error("Interrupt raised without enable or frame");
  a_irq_held: assert property (@(posedge clk_in) disable iff (rst_in)
    anim_irq_out && !anim_irq_ack_in |=> anim_irq_out)
    else $error("Interrupt dropped without acknowledge");
  a_irq_set_wins: assert property (@(posedge clk_in) disable iff (rst_in)
    anim_event && anim_irq_ack_in |=> anim_irq_out)
    else $error("Interrupt lost against acknowledge");
  a_bit_addr_step: assert property (@(posedge clk_in) disable iff (rst_in)
    bitmap_data_we_in && !bitmap_cursor_load_in
      |=> bmp_bit_addr == $past(bmp_bit_addr) + `OBP_BIT_STEP)
    else $error("Bitmap bit address did not advance by eight");
  a_icon_ptr_step: assert property (@(posedge clk_in) disable iff (rst_in)
    icon_data_we_in && !icon_cursor_load_in && icon_write_width_in == 2'h3
      |=> icon_ptr == $past(icon_ptr) + 10'h004)
    else $error("Icon cursor did not advance by four pixels");
  a_auto_swap: assert property (@(posedge clk_in) disable iff (rst_in)
    anim_event && icon_cfg_in.ctrl_a[`OBP_ICA_AUTO] ##1 icon_cfg_in.ctrl_a[`OBP_ICA_AUTO]
      |-> shown_buf != $past(shown_buf))
    else $error("Buffers did not swap on animation event");
  a_icon_on_top: assert property (@(posedge clk_in) disable iff (rst_in)
    icon_vis |=> pix_out.plane == obp_pkg::OBP_PL_ICON)
    else $error("Icon not shown on top");
  a_bmp_layer: assert property (@(posedge clk_in) disable iff (rst_in)
    bmp_vis && !icon_vis && text_vis && !bmp_cfg_in.ctrl_a[`OBP_BCA_BEHIND]
      |=> pix_out.plane == obp_pkg::OBP_PL_BMP)
    else $error("Bitmap not above text");
  a_bypass_blank: assert property (@(posedge clk_in) disable iff (rst_in)
    !text_on_in && !bmp_on && !icon_on |=> pix_out.plane == obp_pkg::OBP_PL_NONE)
    else $error("Output not blank while bypassed");
  a_mask_keeps: assert property (@(posedge clk_in) disable iff (rst_in)
    bitmap_data_we_in && bitmap_write_mask_in == 8'h00 |=> bmp_mem[$past(wb0)] == $past(bwin[15:8]))
    else $error("Masked bitmap write altered data");
endmodule
`default_nettype wire

// >>> obp_planes_tb.sv
// Self-checking bench for the bitmap and pointer overlay planes
`default_nettype none
module obp_planes_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk = 1'b0;
  logic rst, text_on, frame, clk_en, irq, sbuf, bcl, bwe, icl, iwe, ack, abuf;
  obp_pkg::obp_plane_cfg_t bcfg, icfg;
  obp_pkg::obp_pix_t tpix, pix;
  logic [10:0] bmp_w, bmp_h, px, py, bcx, bcy;
  logic [7:0] period, bd, bm, id;
  logic [4:0] icx, icy;
  logic [1:0] iw;
  logic bmem [32768];
  logic [1:0] imem [2][1024];
  int ba, ii, cyc, failures, compares;
  int seed = 55;
  always #5 clk = ~clk;
  obp_host_model u_host (.clk_in(clk), .bcl_out(bcl), .bcx_out(bcx), .bcy_out(bcy),
    .bwe_out(bwe), .bd_out(bd), .bm_out(bm), .icl_out(icl), .icx_out(icx), .icy_out(icy),
    .iwe_out(iwe), .id_out(id), .iw_out(iw), .ack_out(ack));
  obp_planes u_dut (.clk_in(clk), .rst_in(rst), .bmp_cfg_in(bcfg), .bitmap_width_in(bmp_w),
    .bitmap_height_in(bmp_h), .bitmap_cursor_load_in(bcl), .bitmap_cursor_x_in(bcx),
    .bitmap_cursor_y_in(bcy), .bitmap_data_we_in(bwe), .bitmap_pixel_data_in(bd),
    .bitmap_write_mask_in(bm), .icon_cfg_in(icfg), .icon_write_width_in(iw),
    .anim_frame_period_in(period), .icon_cursor_load_in(icl), .icon_cursor_x_in(icx),
    .icon_cursor_y_in(icy), .icon_data_we_in(iwe), .icon_pixel_data_in(id),
    .anim_irq_ack_in(ack), .text_on_in(text_on), .text_pix_in(tpix),
    .frame_start_in(frame), .pix_x_in(px), .pix_y_in(py), .pix_out(pix),
    .osd_clk_en_out(clk_en), .anim_irq_out(irq), .icon_shown_buf_out(sbuf));
  function automatic int bpp();
    return bcfg.ctrl_b[6] ? 4 : (bcfg.ctrl_b[5] ? 2 : 1);
  endfunction
  function automatic logic [3:0] bval(int x, int y);
    logic [3:0] v = 4'h0;
    for (int i = 0; i < bpp(); i++) v = {v[2:0], bmem[((y * bmp_w + x) * bpp() + i) % 32768]};
    return v;
  endfunction
  function automatic logic [13:0] epix(obp_pkg::obp_plane_t p, logic [3:0] c,
                                       logic [7:0] f, logic [7:0] b);
    return {p, c, (c != 4'h0) ? f : b};
  endfunction
  // Expected shown buffer: own toggle model in auto mode, select bit otherwise
  function automatic logic shown();
    return icfg.ctrl_a[7] ? abuf : icfg.ctrl_a[6];
  endfunction
  function automatic logic [13:0] eicon(int col);
    logic [3:0] c = {2'h0, imem[shown()][col]};
    return epix(obp_pkg::OBP_PL_ICON, c, icfg.fore_blend, icfg.back_blend);
  endfunction
  function automatic logic [13:0] ebmp(int x, int y);
    return epix(obp_pkg::OBP_PL_BMP, bval(x, y), bcfg.fore_blend, bcfg.back_blend);
  endfunction
  task automatic step();
    @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [13:0] got, input logic [13:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic see(input int x, input int y, input logic [13:0] exp);
    px = 11'(x);
    py = 11'(y);
    step();
    chk(pix, exp);
  endtask
  task automatic bcur(input int x, input int y);
    ba = (y * bmp_w + x) * bpp();
    u_host.bmp_cur(11'(x), 11'(y));
  endtask
  task automatic bwr(input logic [7:0] d, input logic [7:0] m);
    for (int i = 0; i < 8; i++) if (m[7 - i]) bmem[(ba + i) % 32768] = d[7 - i];
    ba += 8;
    u_host.bmp_wr(d, m);
  endtask
  task automatic iwr(input logic [7:0] d, input logic [1:0] w);
    for (int p = 0; p <= w; p++) imem[!shown()][(ii + p) % 1024] = d[7 - 2 * p -: 2];
    ii += w + 1;
    u_host.icon_wr(d, w);
  endtask
  task automatic frm();
    frame = 1'b1;
    step();
    frame = 1'b0;
    step();
    step();
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", compares, failures);
    if (failures == 0 && compares > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      failures++;
      print_verdict();
    end
  end
  initial begin
    {bcfg, icfg, tpix, px, py, period, text_on, frame, abuf} = '0;
    bmp_w = 11'h010;
    bmp_h = 11'h008;
    rst = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    rst = 1'b0;
    chk({13'h0, clk_en}, 14'h0);
    chk({13'h0, irq}, 14'h0);
    bcfg = {11'd100, 11'd50, 8'h80, 8'h00, 8'h80, 8'h40};
    step();
    chk({13'h0, clk_en}, 14'h1);
    $display("Test bypass done");
    for (int d = 0; d < 4; d++) begin
      bcfg.ctrl_b = {1'b0, 2'(d), 5'h0};
      bcur(0, 0);
      repeat (16 * bpp()) bwr(8'($random(seed)), 8'hff);
      bcur($random(seed) & 15, $random(seed) & 7);
      repeat (4) bwr(8'($random(seed)), 8'($random(seed)));
      u_host.idle();
      for (int y = 0; y < 8; y++) for (int x = 0; x < 16; x++) see(100 + x, 50 + y, ebmp(x, y));
      $display("Test depth code %0d done", d);
    end
    bcfg.pos_x = 11'(200 + ($random(seed) & 63));
    bcfg.ctrl_a[0] = 1'b1;
    for (int x = 0; x < 16; x++) see(bcfg.pos_x + x, 50, ebmp(15 - x, 0));
    for (int x = 0; x < 8; x++) begin
      bcfg.ctrl_a = 8'h88;
      see(bcfg.pos_x + x, 50, ebmp(x / 2, 0));
      bcfg.ctrl_a = 8'h84;
      see(bcfg.pos_x + x, 53, ebmp(3, x));
      bcfg.ctrl_a = 8'h82;
      see(bcfg.pos_x + x, 50, ebmp(x, 7));
    end
    bcfg = {11'd100, 11'd50, 8'h80, 8'h60, 8'h80, 8'h40};
    text_on = 1'b1;
    tpix = {obp_pkg::OBP_PL_TEXT, 4'h7, 8'hff};
    for (int b = 0; b < 2; b++) begin
      bcfg.ctrl_a[6] = b[0];
      for (int x = 0; x < 4; x++) see(100 + x, 51, b ? tpix : ebmp(x, 1));
    end
    bcfg.ctrl_a[6] = 1'b0;
    bcur(0, 0);
    bwr(8'h0f, 8'hff);
    u_host.idle();
    for (int k = 0; k < 4; k++) begin
      bcfg.ctrl_b[4:3] = 2'(k);
      see(100, 50, k[0] ? tpix : ebmp(0, 0));
      see(101, 50, k[1] ? tpix : ebmp(1, 0));
    end
    {bcfg.ctrl_b, bmp_w, bmp_h} = {8'h00, 11'd256, 11'd128};
    bcur(255, 127);
    bwr(8'($random(seed)), 8'hff);
    u_host.idle();
    see(355, 177, ebmp(255, 127));
    for (int x = 0; x < 7; x++) see(100 + x, 50, ebmp(x, 0));
    $display("Test placement and layering done");
    icfg = {11'd100, 11'd50, 8'h00, 8'h80, 8'hc0, 8'h20};
    ii = 0;
    u_host.icon_cur(5'h00, 5'h00);
    repeat (8) iwr(8'($random(seed)), 2'h3);
    for (int w = 0; w < 3; w++) iwr(8'($random(seed)), 2'(w));
    u_host.idle();
    icfg.ctrl_a[6] = 1'b1;
    step();
    chk({13'h0, sbuf}, 14'h1);
    for (int x = 0; x < 32; x++) see(100 + x, 50, eicon(x));
    for (int x = 0; x < 6; x++) see(100 + x, 51, eicon(32 + x));
    for (int x = 0; x < 4; x++) begin
      icfg.ctrl_a = 8'h41;
      see(100 + x, 50, eicon(31 - x));
      icfg.ctrl_a = 8'h48;
      see(100 + x, 50, eicon(x / 2));
      icfg.ctrl_a = 8'h40;
      icfg.ctrl_b = 8'h88;
      see(100 + x, 50, (imem[1][x] == 2'h0) ? ebmp(x, 0) : eicon(x));
      icfg.ctrl_b = 8'h90;
      see(100 + x, 50, (imem[1][x] != 2'h0) ? ebmp(x, 0) : eicon(x));
      icfg.ctrl_b = 8'h80;
    end
    ii = 0;
    u_host.icon_cur(5'h00, 5'h00);
    iwr(8'hff, 2'h3);
    u_host.idle();
    see(100, 50, eicon(0));
    icfg.ctrl_a[6] = 1'b0;
    see(100, 50, eicon(0));
    $display("Test icon done");
    rst = 1'b1;
    step();
    rst = 1'b0;
    {icfg.ctrl_a, icfg.ctrl_b, period} = {8'h80, 8'ha0, 8'h03};
    repeat (2) frm();
    chk({12'h0, irq, sbuf}, 14'h0);
    frm();
    chk({12'h0, irq, sbuf}, 14'h3);
    abuf = 1'b1;
    ii = 0;
    u_host.icon_cur(5'h00, 5'h00);
    repeat (8) iwr(8'($random(seed)), 2'h3);
    u_host.idle();
    repeat (3) frm();
    chk({12'h0, irq, sbuf}, 14'h2);
    abuf = 1'b0;
    for (int x = 0; x < 32; x++) see(100 + x, 50, eicon(x));
    u_host.ack();
    u_host.idle();
    chk({13'h0, irq}, 14'h0);
    icfg.ctrl_b = 8'h80;
    repeat (4) frm();
    chk({12'h0, irq, sbuf}, 14'h0);
    icfg.ctrl_b = 8'ha0;
    frm();
    frame = 1'b1;
    u_host.ack();
    frame = 1'b0;
    u_host.idle();
    chk({12'h0, irq, sbuf}, 14'h3);
    $display("Test animation done");
    print_verdict();
  end
endmodule
`default_nettype wire
